// file: common/dcc_regs.svh
// Register offsets, field positions and reset values of the DMA channel
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
`define DCC_OFF_CTRL 8'h00
`define DCC_OFF_PAD 8'h04
`define DCC_OFF_CNT 8'h08
`define DCC_OFF_BASEA 8'h0C
`define DCC_OFF_BASEB 8'h10
`define DCC_OFF_STAT 8'h14
`define DCC_EN 15
`define DCC_SIZE 14
`define DCC_DIR 13
`define DCC_HALF 12
`define DCC_NULL_WRITE_SELECT 11
`define DCC_AM_HI 5
`define DCC_AM_LO 4
`define DCC_PP 1
`define DCC_ONESHOT 0
`define DCC_CTRL_MASK 16'hF833
`define DCC_CNT_MASK 16'h03FF
`define DCC_WORD_RST 16'h0000
`define DCC_AM_POSTINC 2'h0
`define DCC_AM_NOINC 2'h1
`define DCC_AM_PERIPH 2'h2
`define DCC_CNT_HI 9
`define DCC_RESP_OKAY 2'h0
`define DCC_RESP_DECERR 2'h3
`endif

// file: common/dcc_pkg.sv
// Types shared by the DMA channel design
`default_nettype none
package dcc_pkg;
   typedef logic [15:0] dcc_word_t;
   typedef enum {DCC_IDLE, DCC_READ, DCC_FETCH, DCC_WRITE} dcc_state_e;
endpackage
`default_nettype wire

// file: hdl/dcc_axil_slave.sv
// AXI4-Lite slave front end turning bus cycles into register strobes
`timescale 1ns/1ns
`default_nettype none
`include "dcc_regs.svh"
module dcc_axil_slave #(parameter int ADDR_W = 8) (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Write channels
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read channels
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register side
   output logic wr_en,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic [ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic aw_full;
   logic w_full;

   // Ready terms; a pending response blocks new writes so only one is in flight
   assign awready = ce && !aw_full && !bvalid;
   assign wready = ce && !w_full && !bvalid;
   assign arready = ce && !rvalid;
   assign wr_en = ce && aw_full && w_full && !bvalid;
   assign rd_addr = araddr;

   // Address and data are latched independently, in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
      end
      else if (ce)
      begin
         if (awvalid && awready)
         begin
            aw_full <= 1'b1;
            wr_addr <= awaddr;
         end
         else if (wr_en)
            aw_full <= 1'b0;
         if (wvalid && wready)
         begin
            w_full <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         else if (wr_en)
            w_full <= 1'b0;
      end
   end

   // Write response follows the register update
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= `DCC_RESP_OKAY;
      end
      else if (ce)
      begin
         if (wr_en)
         begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? `DCC_RESP_OKAY : `DCC_RESP_DECERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // Reads have no side effects, so data is sampled at the address edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `DCC_RESP_OKAY;
      end
      else if (ce)
      begin
         if (arvalid && arready)
         begin
            rvalid <= 1'b1;
            rdata <= rd_ok ? rd_data : 32'h00000000;
            rresp <= rd_ok ? `DCC_RESP_OKAY : `DCC_RESP_DECERR;
         end
         else if (rvalid && rready)
            rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: hdl/dcc_top.sv
// DMA channel: register file, transfer engine and block bookkeeping
`timescale 1ns/1ns
`default_nettype none
`include "dcc_regs.svh"
module dcc_top #(parameter int ADDR_W = 8, parameter int RAM_AW = 16) (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Peripheral request
   input wire logic periph_req,
   input wire logic [RAM_AW-1:0] periph_ram_addr,
   // DMA RAM
   output logic [RAM_AW-1:0] ram_addr,
   output logic ram_re,
   output logic ram_we,
   output dcc_pkg::dcc_word_t ram_wdata,
   input wire dcc_pkg::dcc_word_t ram_rdata,
   // Peripheral bus
   output dcc_pkg::dcc_word_t periph_addr,
   output logic periph_re,
   output logic periph_we,
   output dcc_pkg::dcc_word_t periph_wdata,
   input wire dcc_pkg::dcc_word_t periph_rdata,
   // Status and events
   output logic xfer_byte,
   output logic block_irq,
   output logic channel_busy
);
   import dcc_pkg::*;

   dcc_word_t ctrl;
   dcc_word_t pad;
   dcc_word_t cnt;
   dcc_word_t base_a;
   dcc_word_t base_b;
   dcc_state_e state;
   logic pend;
   logic buf_sel;
   logic xfer_dir;
   logic xfer_null;
   logic [10:0] done;
   logic [10:0] next_done;
   logic [10:0] total;
   logic [10:0] irq_point;
   logic [RAM_AW-1:0] offs;
   logic [RAM_AW-1:0] step;
   logic [RAM_AW-1:0] ram_a;
   logic [1:0] addressing_mode_field;
   logic start;
   logic block_end;
   logic hw_stop;
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_ok;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_ok;
   dcc_word_t src_data;

   dcc_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
      .wr_ok(wr_ok), .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
   );

   // Byte-lane merge; the mask keeps unimplemented bits at zero
   function automatic dcc_word_t merge(input dcc_word_t old, input logic [31:0] d,
                                       input logic [3:0] s, input dcc_word_t mask);
      dcc_word_t r;
      r[7:0] = s[0] ? d[7:0] : old[7:0];
      r[15:8] = s[1] ? d[15:8] : old[15:8];
      return r & mask;
   endfunction

   // Read decode; registers sit in the low half of each word
   always_comb
   begin
      rd_ok = 1'b1;
      rd_data = 32'h00000000;
      if (rd_addr == `DCC_OFF_CTRL)
         rd_data = {16'h0000, ctrl};
      else if (rd_addr == `DCC_OFF_PAD)
         rd_data = {16'h0000, pad};
      else if (rd_addr == `DCC_OFF_CNT)
         rd_data = {16'h0000, cnt};
      else if (rd_addr == `DCC_OFF_BASEA)
         rd_data = {16'h0000, base_a};
      else if (rd_addr == `DCC_OFF_BASEB)
         rd_data = {16'h0000, base_b};
      else if (rd_addr == `DCC_OFF_STAT)
         rd_data = {29'h0, buf_sel, pend, channel_busy};
      else
         rd_ok = 1'b0;
   end

   // Write decode; status accepts writes and ignores them
   always_comb
   begin
      wr_ok = 1'b1;
      if (wr_addr == `DCC_OFF_CTRL || wr_addr == `DCC_OFF_PAD)
         wr_ok = 1'b1;
      else if (wr_addr == `DCC_OFF_CNT || wr_addr == `DCC_OFF_BASEA)
         wr_ok = 1'b1;
      else if (wr_addr == `DCC_OFF_BASEB || wr_addr == `DCC_OFF_STAT)
         wr_ok = 1'b1;
      else
         wr_ok = 1'b0;
   end

   // Control register; a software write in the stop cycle wins over the stop
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl <= `DCC_WORD_RST;
      else if (ce)
      begin
         if (wr_en && wr_addr == `DCC_OFF_CTRL)
            ctrl <= merge(ctrl, wr_data, wr_strb, `DCC_CTRL_MASK);
         else if (hw_stop)
            ctrl[`DCC_EN] <= 1'b0;
      end
   end

   // Address, count and buffer bases; changing them mid-run is not guarded
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pad <= `DCC_WORD_RST;
         cnt <= `DCC_WORD_RST;
         base_a <= `DCC_WORD_RST;
         base_b <= `DCC_WORD_RST;
      end
      else if (ce && wr_en)
      begin
         if (wr_addr == `DCC_OFF_PAD)
            pad <= merge(pad, wr_data, wr_strb, 16'hFFFF);
         else if (wr_addr == `DCC_OFF_CNT)
            cnt <= merge(cnt, wr_data, wr_strb, `DCC_CNT_MASK);
         else if (wr_addr == `DCC_OFF_BASEA)
            base_a <= merge(base_a, wr_data, wr_strb, 16'hFFFF);
         else if (wr_addr == `DCC_OFF_BASEB)
            base_b <= merge(base_b, wr_data, wr_strb, 16'hFFFF);
      end
   end

   // Block arithmetic
   assign addressing_mode_field = ctrl[`DCC_AM_HI:`DCC_AM_LO];
   assign total = {1'b0, cnt[`DCC_CNT_HI:0]} + 11'h001;
   assign irq_point = ctrl[`DCC_HALF] ? ((total + 11'h001) >> 1) : total;
   assign next_done = done + 11'h001;
   assign block_end = (state == DCC_WRITE) && (next_done == total);
   assign hw_stop = block_end && ctrl[`DCC_ONESHOT] && (!ctrl[`DCC_PP] || buf_sel);
   assign step = ctrl[`DCC_SIZE] ? RAM_AW'(1) : RAM_AW'(2);
   assign start = (state == DCC_IDLE) && ctrl[`DCC_EN] && (pend || periph_req);
   assign channel_busy = (state != DCC_IDLE);
   assign src_data = xfer_dir ? ram_rdata : periph_rdata;

   // RAM address by addressing mode; reserved code behaves as fixed address
   always_comb
   begin
      ram_a = (buf_sel ? RAM_AW'(base_b) : RAM_AW'(base_a)) + offs;
      if (addressing_mode_field == `DCC_AM_PERIPH)
         ram_a = periph_ram_addr;
   end

   // Request latch; a request arriving while busy is kept, set wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pend <= 1'b0;
      else if (ce)
      begin
         if (!ctrl[`DCC_EN])
            pend <= 1'b0;
         else if (periph_req && (state != DCC_IDLE || pend))
            pend <= 1'b1;
         else if (start)
            pend <= 1'b0;
      end
   end

   // Transfer engine: read strobe, data capture, write strobe
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= DCC_IDLE;
         ram_addr <= '0;
         ram_re <= 1'b0;
         ram_we <= 1'b0;
         ram_wdata <= `DCC_WORD_RST;
         periph_addr <= `DCC_WORD_RST;
         periph_re <= 1'b0;
         periph_we <= 1'b0;
         periph_wdata <= `DCC_WORD_RST;
         xfer_byte <= 1'b0;
         xfer_dir <= 1'b0;
         xfer_null <= 1'b0;
      end
      else if (ce)
      begin
         case (state)
            DCC_IDLE:
               if (start)
               begin
                  state <= DCC_READ;
                  xfer_byte <= ctrl[`DCC_SIZE];
                  xfer_dir <= ctrl[`DCC_DIR];
                  xfer_null <= ctrl[`DCC_NULL_WRITE_SELECT] && !ctrl[`DCC_DIR];
                  ram_addr <= ram_a;
                  periph_addr <= pad;
                  ram_re <= ctrl[`DCC_DIR];
                  periph_re <= !ctrl[`DCC_DIR];
               end
            DCC_READ:
            begin
               ram_re <= 1'b0;
               periph_re <= 1'b0;
               state <= DCC_FETCH;
            end
            DCC_FETCH:
            begin
               state <= DCC_WRITE;
               if (xfer_dir)
               begin
                  periph_we <= 1'b1;
                  periph_wdata <= xfer_byte ? {8'h00, src_data[7:0]} : src_data;
               end
               else
               begin
                  ram_we <= 1'b1;
                  ram_wdata <= xfer_byte ? {8'h00, src_data[7:0]} : src_data;
                  periph_we <= xfer_null;
                  periph_wdata <= `DCC_WORD_RST;
               end
            end
            default:
            begin
               ram_we <= 1'b0;
               periph_we <= 1'b0;
               state <= DCC_IDLE;
            end
         endcase
      end
   end

   // Block progress, buffer selection and completion pulse
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         done <= '0;
         offs <= '0;
         buf_sel <= 1'b0;
         block_irq <= 1'b0;
      end
      else if (ce)
      begin
         block_irq <= (state == DCC_WRITE) && (next_done == irq_point);
         if (!ctrl[`DCC_EN] && state == DCC_IDLE)
         begin
            done <= '0;
            offs <= '0;
            buf_sel <= 1'b0;
         end
         else if (block_end)
         begin
            done <= '0;
            offs <= '0;
            if (ctrl[`DCC_PP])
               buf_sel <= !buf_sel;
         end
         else if (state == DCC_WRITE)
         begin
            done <= next_done;
            if (addressing_mode_field == `DCC_AM_POSTINC)
               offs <= offs + step;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);

   sequence s_xfer;
      state == DCC_READ ##1 state == DCC_FETCH ##1 state == DCC_WRITE;
   endsequence

   // Only the strobed side is judged; an idle RAM side still holds its last word
   property p_byte_upper;
      xfer_byte |-> (!ram_we || ram_wdata[15:8] == 8'h00)
         && (!periph_we || periph_wdata[15:8] == 8'h00);
   endproperty
   a_byte_upper: assert property (p_byte_upper) else $error("byte transfer upper lane set");

   property p_dir;
      state == DCC_READ |-> ram_re == xfer_dir && periph_re == !xfer_dir ##2 ram_we == !xfer_dir;
   endproperty
   a_dir: assert property (p_dir) else $error("transfer direction wrong");

   property p_irq_cause;
      block_irq |-> $past(state) == DCC_WRITE && $past(next_done) == $past(irq_point);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("completion pulse misplaced");

   property p_null;
      ram_we && xfer_null |-> periph_we && periph_wdata == 16'h0000;
   endproperty
   a_null: assert property (p_null) else $error("null write missing");

   property p_noinc;
      state == DCC_IDLE && start && addressing_mode_field == `DCC_AM_NOINC && !buf_sel
         |=> ram_addr == RAM_AW'(base_a);
   endproperty
   a_noinc: assert property (p_noinc) else $error("fixed address moved");

   property p_swap;
      block_end && ctrl[`DCC_PP] |=> buf_sel != $past(buf_sel);
   endproperty
   a_swap: assert property (p_swap) else $error("ping-pong buffer not swapped");

   property p_count;
      block_end |-> done == {1'b0, cnt[`DCC_CNT_HI:0]};
   endproperty
   a_count: assert property (p_count) else $error("block length wrong");

   property p_cnt_read;
      rd_addr == `DCC_OFF_CNT |-> rd_data[31:10] == 22'h000000;
   endproperty
   a_cnt_read: assert property (p_cnt_read) else $error("count upper bits not zero");

   property p_start_en;
      state == DCC_IDLE ##1 state == DCC_READ |-> $past(ctrl[`DCC_EN]);
   endproperty
   a_start_en: assert property (p_start_en) else $error("started while disabled");

   property p_steps;
      state == DCC_READ && $past(state) == DCC_IDLE |-> s_xfer ##1 state == DCC_IDLE;
   endproperty
   a_steps: assert property (p_steps) else $error("transfer sequence broken");

   property p_oneshot;
      hw_stop && !(wr_en && wr_addr == `DCC_OFF_CTRL) |=> !ctrl[`DCC_EN];
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");
endmodule
`default_nettype wire

// file: testbench/dcc_partner.sv
// Behavioural DMA RAM and peripheral data register on the far side of the channel
`timescale 1ns/1ns
`default_nettype none
module dcc_partner (
   // Clock
   input wire logic aclk,
   // DMA RAM side
   input wire logic [15:0] ram_addr,
   input wire logic ram_re,
   input wire logic ram_we,
   input wire logic [15:0] ram_wdata,
   output logic [15:0] ram_rdata,
   // Peripheral side
   input wire logic [15:0] periph_addr,
   input wire logic periph_re,
   input wire logic periph_we,
   input wire logic [15:0] periph_wdata,
   output logic [15:0] periph_rdata,
   output logic [15:0] last_pwdata
);
   logic [15:0] mem [0:255];

   // Known start so the first edges see no unknowns
   initial
   begin
      ram_rdata = 16'h0000;
      periph_rdata = 16'h0000;
      last_pwdata = 16'h0000;
   end

   // Read data is valid only one cycle after a strobe; otherwise it toggles,
   // so a design that samples late picks up garbage instead of a lucky value
   always @(posedge aclk)
   begin
      ram_rdata <= ram_re ? mem[ram_addr[7:0]] : ~ram_rdata;
      periph_rdata <= periph_re ? (periph_addr ^ 16'h3C5A) : ~periph_rdata;
      if (ram_we)
         mem[ram_addr[7:0]] <= ram_wdata;
      if (periph_we)
         last_pwdata <= periph_wdata;
   end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the DMA channel
`timescale 1ns/1ns
`default_nettype none
`include "dcc_regs.svh"
module tb_top;
   import dcc_pkg::*;
   // Stimulus
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic periph_req = 1'b0;
   logic [15:0] periph_ram_addr = 16'h0060;
   // Design outputs
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] ram_addr, last_pwdata;
   logic ram_re, ram_we, periph_re, periph_we, xfer_byte, block_irq, channel_busy;
   dcc_word_t ram_wdata, ram_rdata, periph_addr, periph_wdata, periph_rdata;
   // Scoreboard
   int mismatches = 0;
   int cmp_count = 0;
   int n_xf, n_null, n_irq, irq_at, bad_pad, n_busy;
   logic last_byte;
   logic [15:0] pad_exp = 16'h0000;

   always #20 aclk = ~aclk;

   dcc_top #(.ADDR_W(8), .RAM_AW(16)) i_dcc_top (.aclk, .aresetn, .ce, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .periph_req, .periph_ram_addr,
      .ram_addr, .ram_re, .ram_we, .ram_wdata, .ram_rdata, .periph_addr, .periph_re,
      .periph_we, .periph_wdata, .periph_rdata, .xfer_byte, .block_irq, .channel_busy);

   dcc_partner i_dcc_partner (.aclk, .ram_addr, .ram_re, .ram_we, .ram_wdata, .ram_rdata,
      .periph_addr, .periph_re, .periph_we, .periph_wdata, .periph_rdata, .last_pwdata);

   // Count finished transfers, null writes, completion pulses and stray addresses
   always @(posedge aclk)
   begin
      if (ram_we === 1'b1 || periph_we === 1'b1)
      begin
         n_xf++;
         last_byte = xfer_byte;
      end
      if (ram_we === 1'b1 && periph_we === 1'b1 && periph_wdata === 16'h0000)
         n_null++;
      if (block_irq === 1'b1)
      begin
         n_irq++;
         irq_at = n_xf;
      end
      if ((periph_re === 1'b1 || periph_we === 1'b1) && periph_addr !== pad_exp)
         bad_pad++;
      if (channel_busy === 1'b1)
         n_busy++;
   end

   task finish_test;
      if (mismatches == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task chk_n(input int got, input int exp);
      cmp_count++;
      if (got != exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Handshakes are judged at the falling edge, where the readys have settled,
   // and acted on right after the next rising edge
   task axi_wr(input logic [7:0] a, input logic [15:0] d);
      logic aw_hs, w_hs, b_hs;
      logic [1:0] r;
      b_hs = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_hs)
      begin
         @(negedge aclk);
         aw_hs = awvalid & awready;
         w_hs = wvalid & wready;
         b_hs = bvalid & bready;
         r = bresp;
         @(posedge aclk);
         if (aw_hs)
            awvalid <= 1'b0;
         if (w_hs)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
      chk({30'h0, r}, {30'h0, `DCC_RESP_OKAY});
   endtask

   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_hs, r_hs;
      r_hs = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_hs)
      begin
         @(negedge aclk);
         ar_hs = arvalid & arready;
         r_hs = rvalid & rready;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ar_hs)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   task rd_chk(input logic [7:0] a, input logic [15:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(d, {16'h0000, e});
      chk({30'h0, r}, {30'h0, `DCC_RESP_OKAY});
   endtask

   // One-cycle requests spaced wider than a whole transfer
   task req(input int n);
      repeat (n)
      begin
         @(posedge aclk);
         periph_req <= 1'b1;
         @(posedge aclk);
         periph_req <= 1'b0;
         repeat (6) @(posedge aclk);
      end
   endtask

   // Address and count are only touched while the channel is off
   task cfg(input logic [15:0] pad, input logic [15:0] cnt, input logic [15:0] ctrl);
      pad_exp = pad;
      axi_wr(`DCC_OFF_PAD, pad);
      axi_wr(`DCC_OFF_CNT, cnt);
      n_xf = 0;
      n_null = 0;
      n_irq = 0;
      bad_pad = 0;
      n_busy = 0;
      axi_wr(`DCC_OFF_CTRL, ctrl);
   endtask

   task t_regs;
      logic [31:0] d;
      logic [1:0] r;
      rd_chk(`DCC_OFF_CTRL, 16'h0000);
      rd_chk(`DCC_OFF_PAD, 16'h0000);
      rd_chk(`DCC_OFF_CNT, 16'h0000);
      axi_wr(`DCC_OFF_PAD, 16'hA5C3);
      rd_chk(`DCC_OFF_PAD, 16'hA5C3);
      // Upper lane only; the low byte must survive the partial write
      @(posedge aclk);
      wstrb <= 4'h2;
      axi_wr(`DCC_OFF_PAD, 16'h0F00);
      wstrb <= 4'hF;
      rd_chk(`DCC_OFF_PAD, 16'h0FC3);
      axi_wr(`DCC_OFF_CNT, 16'hFFFF);
      rd_chk(`DCC_OFF_CNT, 16'h03FF);
      axi_wr(`DCC_OFF_CTRL, 16'h07CC);
      rd_chk(`DCC_OFF_CTRL, 16'h0000);
      axi_rd(8'h18, d, r);
      chk(d, 32'h00000000);
      chk({30'h0, r}, {30'h0, `DCC_RESP_DECERR});
   endtask

   task t_word_in;
      axi_wr(`DCC_OFF_BASEA, 16'h0020);
      cfg(16'h1234, 16'h0002, 16'h8001);
      req(3);
      chk_n(n_xf, 3);
      chk_n(n_busy, 9);
      chk(i_dcc_partner.mem[8'h20], 16'h1234 ^ 16'h3C5A);
      chk(i_dcc_partner.mem[8'h24], 16'h1234 ^ 16'h3C5A);
      chk_n(irq_at, 3);
      chk_n(n_irq, 1);
      chk({31'h0, last_byte}, 32'h0);
      rd_chk(`DCC_OFF_CTRL, 16'h0001);
      req(1);
      chk_n(n_xf, 3);
      chk_n(bad_pad, 0);
   endtask

   task t_byte_out;
      i_dcc_partner.mem[8'h40] = 16'hBEEF;
      i_dcc_partner.mem[8'h43] = 16'h1111;
      axi_wr(`DCC_OFF_BASEA, 16'h0040);
      cfg(16'h0300, 16'h0003, 16'hF011);
      req(4);
      chk_n(n_xf, 4);
      chk_n(irq_at, 2);
      chk(last_pwdata, 16'h00EF);
      chk(i_dcc_partner.mem[8'h40], 16'hBEEF);
      chk({31'h0, last_byte}, 32'h1);
      rd_chk(`DCC_OFF_CTRL, 16'h7011);
   endtask

   task t_null;
      i_dcc_partner.mem[8'h60] = 16'h0000;
      cfg(16'h0555, 16'h0000, 16'h8820);
      req(2);
      chk(i_dcc_partner.mem[8'h60], 16'h0555 ^ 16'h3C5A);
      chk_n(n_null, 2);
      chk_n(n_irq, 2);
      rd_chk(`DCC_OFF_CTRL, 16'h8820);
      axi_wr(`DCC_OFF_CTRL, 16'h0000);
      req(1);
      chk_n(n_xf, 2);
   endtask

   task t_pingpong;
      i_dcc_partner.mem[8'h80] = 16'h0000;
      i_dcc_partner.mem[8'hA0] = 16'h0000;
      axi_wr(`DCC_OFF_BASEA, 16'h0080);
      axi_wr(`DCC_OFF_BASEB, 16'h00A0);
      cfg(16'h0F0F, 16'h0000, 16'h8003);
      req(3);
      chk_n(n_xf, 2);
      chk(i_dcc_partner.mem[8'hA0], 16'h0F0F ^ 16'h3C5A);
      rd_chk(`DCC_OFF_CTRL, 16'h0003);
      i_dcc_partner.mem[8'hA0] = 16'h0000;
      cfg(16'h0F0F, 16'h0000, 16'h8002);
      req(1);
      chk(i_dcc_partner.mem[8'hA0], 16'h0000);
      req(2);
      chk_n(n_xf, 3);
      chk(i_dcc_partner.mem[8'hA0], 16'h0F0F ^ 16'h3C5A);
      rd_chk(`DCC_OFF_CTRL, 16'h8002);
      axi_wr(`DCC_OFF_CTRL, 16'h0000);
   endtask

   // A hung handshake ends the run here instead of stalling forever
   initial
   begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      finish_test();
   end

   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_word_in();
      t_byte_out();
      t_null();
      t_pingpong();
      finish_test();
   end
endmodule
`default_nettype wire
